// *** core/pap_precharge.sv ***
// precharge and auto-precharge engine for eight banks, with register port
// assumes cs_pin/ca_pin arrive asynchronously and the host keeps its spacing
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
module pap_precharge (
  input  wire logic        sys_clk,    // 100 MHz clock
  input  wire logic        reset,      // sync reset, high
  input  wire logic        ce,         // clock enable, freezes all
  input  wire logic        cs_pin,     // chip select pin
  input  wire logic [5:0]  ca_pin,     // command/address pins
  input  wire logic [7:0]  addr,       // register byte address
  input  wire logic [31:0] wdata,      // register write data
  input  wire logic        wr_stb,     // register write strobe
  input  wire logic        rd_stb,     // register read strobe
  output logic      [31:0] rd_data,    // read data, next cycle
  output logic      [7:0]  bank_open,  // bank holds an open row
  output logic      [7:0]  bank_prech  // bank is precharging
);
  `include "pap_consts.svh"

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic       cs_m_q, cs_s_q;
  logic [5:0] ca_m_q, ca_s_q;

  // two stages; only the second stage feeds logic
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs_m_q <= 1'b0;
      cs_s_q <= 1'b0;
      ca_m_q <= 6'h00;
      ca_s_q <= 6'h00;
    end else if (ce) begin
      cs_m_q <= cs_pin;
      cs_s_q <= cs_m_q;
      ca_m_q <= ca_pin;
      ca_s_q <= ca_m_q;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  pap_cmd_if cmd_if ();

  pap_cmd_dec u_dec (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ce      (ce),
    .cs      (cs_s_q),
    .ca      (ca_s_q),
    .cmd     (cmd_if)
  );

  // bank address match, used for every event kind
  function automatic logic bank_sel(input logic [2:0] ba, input logic [2:0] idx);
    bank_sel = (ba == idx);
  endfunction : bank_sel

  logic is_pre, is_rd, is_wr;
  assign is_pre = cmd_if.valid && (cmd_if.kind == pap_pkg::cmd_pre);
  assign is_rd  = cmd_if.valid && (cmd_if.kind == pap_pkg::cmd_rd);
  assign is_wr  = cmd_if.valid && ((cmd_if.kind == pap_pkg::cmd_wr) ||
                                   (cmd_if.kind == pap_pkg::cmd_mwr));

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] tim0_q, tim0_d;
  logic [31:0] tim1_q, tim1_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0]  open_q, open_d;
  logic [7:0]  prech_q, prech_d;
  logic [7:0]  open_w, prech_w, apw_w;

  // writes steer timing; reads show live bank state, unmapped reads give 0
  always_comb begin
    ctrl_d  = ctrl_q;
    tim0_d  = tim0_q;
    tim1_d  = tim1_q;
    rdat_d  = 32'h0000_0000;
    open_d  = open_w;
    prech_d = prech_w;
    if (wr_stb) begin
      if (addr == `PAP_ADDR_CTRL)      ctrl_d = wdata;
      else if (addr == `PAP_ADDR_TIM0) tim0_d = wdata;
      else if (addr == `PAP_ADDR_TIM1) tim1_d = wdata;
    end
    if (rd_stb) begin
      if (addr == `PAP_ADDR_CTRL)      rdat_d = {31'h0000_0000, ctrl_q[`PAP_CTRL_BL32]};
      else if (addr == `PAP_ADDR_TIM0) rdat_d = {8'h00, tim0_q[23:0]};
      else if (addr == `PAP_ADDR_TIM1) rdat_d = {8'h00, tim1_q[23:0]};
      else if (addr == `PAP_ADDR_STAT) rdat_d = {8'h00, apw_w, prech_w, open_w};
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_q  <= `PAP_CTRL_RST;
      tim0_q  <= `PAP_TIM0_RST;
      tim1_q  <= `PAP_TIM1_RST;
      rdat_q  <= 32'h0000_0000;
      open_q  <= 8'h00;
      prech_q <= 8'h00;
    end else if (ce) begin
      ctrl_q  <= ctrl_d;
      tim0_q  <= tim0_d;
      tim1_q  <= tim1_d;
      rdat_q  <= rdat_d;
      open_q  <= open_d;
      prech_q <= prech_d;
    end
  end

  assign rd_data    = rdat_q;
  assign bank_open  = open_q;
  assign bank_prech = prech_q;

  // ----------------------------------------
  // derived timing counts
  // ----------------------------------------
  logic       bl32;
  logic [9:0] trppb_e, trpab_e, half_bl, rd_dly, wr_dly;

  assign bl32    = ctrl_q[`PAP_CTRL_BL32];
  // a zero tRP field is raised to one cycle, the floor
  assign trppb_e = (tim0_q[`PAP_TIM0_RPPB +: 8] == 8'h00) ? 10'h001 : {2'b00, tim0_q[`PAP_TIM0_RPPB +: 8]};
  // all-bank time is forced past per-bank to cap current draw
  assign trpab_e = ({2'b00, tim0_q[`PAP_TIM0_RPAB +: 8]} > trppb_e) ?
                   {2'b00, tim0_q[`PAP_TIM0_RPAB +: 8]} : trppb_e + 10'h001;
  assign half_bl = bl32 ? `PAP_HALF_BL32 : `PAP_HALF_BL16;
  // read ap waits nRTP, plus 8 at BL32
  assign rd_dly  = {2'b00, tim1_q[`PAP_TIM1_RTP +: 8]} + (bl32 ? `PAP_BL32_RD_EXTRA : 10'h000);
  // write ap waits for burst end then tWR
  assign wr_dly  = {2'b00, tim1_q[`PAP_TIM1_WL +: 8]} + half_bl + `PAP_WR_EXTRA +
                   {2'b00, tim1_q[`PAP_TIM1_WR +: 8]};

  // ----------------------------------------
  // banks
  // ----------------------------------------
  pap_pkg::pap_bank_st_t st_w [8];
  logic [7:0] act_w, pre_w, aprd_w, apwr_w, rasok_w, start_w;
  logic [9:0] age_q [8];
  logic [9:0] age_d [8];
  logic [9:0] need_q [8];
  logic [9:0] need_d [8];
  logic [7:0] isrd_q, isrd_d;

  for (genvar g = 0; g < 8; g++) begin : g_bank
    localparam logic [2:0] IDX = 3'(g);

    // bank selection: for precharge ca5 takes all banks, else bank field; activate uses the bank field only
    assign act_w[g]  = cmd_if.valid && (cmd_if.kind == pap_pkg::cmd_act) && bank_sel(cmd_if.bank, IDX);
    assign pre_w[g]  = is_pre && (cmd_if.flag || bank_sel(cmd_if.bank, IDX));
    // only a set ap bit engages; clear leaves the bank open
    assign aprd_w[g] = is_rd && cmd_if.flag && bank_sel(cmd_if.bank, IDX);
    assign apwr_w[g] = is_wr && cmd_if.flag && bank_sel(cmd_if.bank, IDX);

    pap_bank u_bank (
      .sys_clk (sys_clk),
      .reset   (reset),
      .ce      (ce),
      .act     (act_w[g]),
      .pre     (pre_w[g]),
      .pre_ab  (cmd_if.flag),
      .ap_rd   (aprd_w[g]),
      .ap_wr   (apwr_w[g]),
      .trp_pb  (trppb_e),
      .trp_ab  (trpab_e),
      .ras     (tim0_q[`PAP_TIM0_RAS +: 8]),
      .rd_dly  (rd_dly),
      .wr_dly  (wr_dly),
      .st      (st_w[g]),
      .ras_ok  (rasok_w[g]),
      .start   (start_w[g])
    );

    assign open_w[g]  = (st_w[g] == pap_pkg::bk_open) || (st_w[g] == pap_pkg::bk_apwait);
    assign prech_w[g] = (st_w[g] == pap_pkg::bk_prech);
    assign apw_w[g]   = (st_w[g] == pap_pkg::bk_apwait);

    // helper: age since an ap command and the wait it asked for
    always_comb begin
      age_d[g]  = (age_q[g] == 10'h3FF) ? age_q[g] : age_q[g] + 10'h001;
      need_d[g] = need_q[g];
      isrd_d[g] = isrd_q[g];
      if ((aprd_w[g] || apwr_w[g]) && (st_w[g] == pap_pkg::bk_open)) begin
        age_d[g]  = 10'h001;
        need_d[g] = aprd_w[g] ? rd_dly : wr_dly;
        if (need_d[g] < `PAP_MIN_AP_DLY) need_d[g] = `PAP_MIN_AP_DLY;
        isrd_d[g] = aprd_w[g];
      end
    end

    // helper registers
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        age_q[g]  <= 10'h000;
        need_q[g] <= 10'h000;
        isrd_q[g] <= 1'b0;
      end else if (ce) begin
        age_q[g]  <= age_d[g];
        need_q[g] <= need_d[g];
        isrd_q[g] <= isrd_d[g];
      end
    end

    // ----------------------------------------
    // per-bank checks
    // ----------------------------------------
    pre_close_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
      pre_w[g] && open_w[g] |=> prech_w[g])
      else $error("precharge did not close an open bank");

    one_bank_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
      is_pre && !cmd_if.flag && !bank_sel(cmd_if.bank, IDX) && (st_w[g] == pap_pkg::bk_open)
      |=> (st_w[g] == pap_pkg::bk_open))
      else $error("single-bank precharge touched another bank");

    ap_engage_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
      (aprd_w[g] || apwr_w[g]) && (st_w[g] == pap_pkg::bk_open) |=> apw_w[g])
      else $error("ap bit did not engage auto-precharge");

    ap_low_open_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
      (is_rd || is_wr) && !cmd_if.flag && bank_sel(cmd_if.bank, IDX) && (st_w[g] == pap_pkg::bk_open)
      |=> (st_w[g] == pap_pkg::bk_open) [*2])
      else $error("bank closed without ap bit");

    rd_ap_time_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
      start_w[g] && isrd_q[g] |-> (age_q[g] == need_q[g]) ||
                                   ((age_q[g] > need_q[g]) && !$past(rasok_w[g], 2)))
      else $error("read auto-precharge began at the wrong cycle");

    wr_ap_time_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
      start_w[g] && !isrd_q[g] |-> (age_q[g] == need_q[g]) ||
                                    ((age_q[g] > need_q[g]) && !$past(rasok_w[g], 2)))
      else $error("write auto-precharge began at the wrong cycle");

    ras_lock_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
      apw_w[g] && !rasok_w[g] && !pre_w[g] |=> !start_w[g] && apw_w[g])
      else $error("auto-precharge began before tRAS");
  end

  // ----------------------------------------
  // block-wide checks
  // ----------------------------------------
  logic [4:0] op_s_w;
  assign op_s_w = ca_s_q[4:0];

  all_bank_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
    is_pre && cmd_if.flag |=> (open_w == 8'h00))
    else $error("all-bank precharge left a bank open");

  rp_order_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
    trpab_e > trppb_e)
    else $error("all-bank tRP not longer than per-bank tRP");

  pre_code_a : assert property (@(posedge sys_clk) disable iff (reset || !ce)
    is_pre |-> $past(cs_s_q, 2) && ($past(op_s_w, 2) == `PAP_OP_PRE))
    else $error("precharge decoded without its cs and ca code");

  // main scenarios
  rd_ap_cov : cover property (@(posedge sys_clk) disable iff (reset) |(start_w & isrd_q));
  wr_ap_cov : cover property (@(posedge sys_clk) disable iff (reset) |(start_w & ~isrd_q));
  ab_pre_cov : cover property (@(posedge sys_clk) disable iff (reset) is_pre && cmd_if.flag && |open_w);
  lock_cov : cover property (@(posedge sys_clk) disable iff (reset) |(apw_w & ~rasok_w));
endmodule : pap_precharge

// *** core/pap_consts.svh ***
// register offsets, field positions, reset values and command codes
// assumes a 100 MHz sys_clk; all timing figures are counts of that clock
`ifndef PAP_CONSTS_SVH
`define PAP_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PAP_ADDR_CTRL     8'h00
`define PAP_ADDR_TIM0     8'h04
`define PAP_ADDR_TIM1     8'h08
`define PAP_ADDR_STAT     8'h0C
// ----------------------------------------
// field positions
// ----------------------------------------
`define PAP_CTRL_BL32     0
`define PAP_TIM0_RPPB     0
`define PAP_TIM0_RPAB     8
`define PAP_TIM0_RAS      16
`define PAP_TIM1_RTP      0
`define PAP_TIM1_WR       8
`define PAP_TIM1_WL       16
// ----------------------------------------
// reset values
// ----------------------------------------
`define PAP_CTRL_RST      32'h0000_0000
`define PAP_TIM0_RST      32'h002D_1612
`define PAP_TIM1_RST      32'h000A_0E08
// ----------------------------------------
// command codes on ca[4:0] of the first cycle
// ----------------------------------------
`define PAP_OP_ACT_LO     2'h1
`define PAP_OP_PRE        5'h10
`define PAP_OP_RD         5'h02
`define PAP_OP_WR         5'h04
`define PAP_OP_MWR        5'h06
// ----------------------------------------
// burst timing counts
// ----------------------------------------
`define PAP_HALF_BL16     10'h008
`define PAP_HALF_BL32     10'h010
`define PAP_BL32_RD_EXTRA 10'h008
`define PAP_WR_EXTRA      10'h001
`define PAP_MIN_AP_DLY    10'h002
`endif

// *** core/pap_pkg.sv ***
// types shared by the precharge block
// assumes nothing beyond a SystemVerilog compiler
package pap_pkg;
  // decoded command kinds
  typedef enum logic [2:0] {
    cmd_none, cmd_act, cmd_rd, cmd_wr, cmd_mwr, cmd_pre
  } pap_cmd_t;
  // per-bank row state
  typedef enum logic [1:0] {
    bk_closed, bk_open, bk_apwait, bk_prech
  } pap_bank_st_t;
  // two-cycle command capture
  typedef enum logic {
    dec_idle, dec_arg
  } pap_dec_st_t;
endpackage : pap_pkg

// *** core/pap_cmd_if.sv ***
// decoded command carrier from the command decoder to the bank logic
// assumes both ends sit on the same sys_clk
`timescale 1ns/1ps
interface pap_cmd_if;
  logic              valid; // one-cycle command pulse
  pap_pkg::pap_cmd_t kind;  // command kind
  logic [2:0]        bank;  // bank address
  logic              flag;  // all-bank or auto-precharge bit
  modport src (output valid, output kind, output bank, output flag);
  modport snk (input valid, input kind, input bank, input flag);
endinterface : pap_cmd_if

// *** core/pap_cmd_dec.sv ***
// two-cycle command decoder: first cycle gives op and flag, second the bank
// assumes cs and ca are already synchronised to sys_clk
`timescale 1ns/1ps
module pap_cmd_dec (
  input  wire logic       sys_clk, // system clock
  input  wire logic       reset,   // sync reset, high
  input  wire logic       ce,      // clock enable
  input  wire logic       cs,      // chip select, synced
  input  wire logic [5:0] ca,      // command/address, synced
  pap_cmd_if.src          cmd      // decoded command
);
  `include "pap_consts.svh"

  // op code to command kind
  function automatic pap_pkg::pap_cmd_t op_decode(input logic [4:0] op);
    if (op[1:0] == `PAP_OP_ACT_LO) op_decode = pap_pkg::cmd_act;
    else if (op == `PAP_OP_PRE)    op_decode = pap_pkg::cmd_pre;
    else if (op == `PAP_OP_RD)     op_decode = pap_pkg::cmd_rd;
    else if (op == `PAP_OP_WR)     op_decode = pap_pkg::cmd_wr;
    else if (op == `PAP_OP_MWR)    op_decode = pap_pkg::cmd_mwr;
    else                           op_decode = pap_pkg::cmd_none;
  endfunction : op_decode

  pap_pkg::pap_dec_st_t st_q,   st_d;
  pap_pkg::pap_cmd_t    kind_q, kind_d;
  logic                 flag_q, flag_d;
  logic                 v_q,    v_d;
  logic [2:0]           bank_q, bank_d;

  // first cycle latches op and ca5, second cycle the bank field
  always_comb begin
    st_d   = st_q;
    kind_d = kind_q;
    flag_d = flag_q;
    bank_d = bank_q;
    v_d    = 1'b0;
    case (st_q)
      pap_pkg::dec_idle: begin
        if (cs) begin
          kind_d = op_decode(ca[4:0]);
          flag_d = ca[5];
          st_d   = pap_pkg::dec_arg;
        end
      end
      pap_pkg::dec_arg: begin
        bank_d = ca[2:0];
        v_d    = (kind_q != pap_pkg::cmd_none);
        st_d   = pap_pkg::dec_idle;
      end
      default: st_d = pap_pkg::dec_idle;
    endcase
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q   <= pap_pkg::dec_idle;
      kind_q <= pap_pkg::cmd_none;
      flag_q <= 1'b0;
      bank_q <= 3'h0;
      v_q    <= 1'b0;
    end else if (ce) begin
      st_q   <= st_d;
      kind_q <= kind_d;
      flag_q <= flag_d;
      bank_q <= bank_d;
      v_q    <= v_d;
    end
  end

  assign cmd.valid = v_q;
  assign cmd.kind  = kind_q;
  assign cmd.flag  = flag_q;
  assign cmd.bank  = bank_q;
endmodule : pap_cmd_dec

// *** core/pap_bank.sv ***
// one bank: open/closed state, tRAS age, auto-precharge wait and tRP countdown
// assumes at most one event input is high per cycle
`timescale 1ns/1ps
module pap_bank (
  input  wire logic                  sys_clk, // system clock
  input  wire logic                  reset,   // sync reset, high
  input  wire logic                  ce,      // clock enable
  input  wire logic                  act,     // activate this bank
  input  wire logic                  pre,     // precharge this bank
  input  wire logic                  pre_ab,  // precharge was all-bank
  input  wire logic                  ap_rd,   // read with auto-precharge
  input  wire logic                  ap_wr,   // write with auto-precharge
  input  wire logic [9:0]            trp_pb,  // per-bank tRP count
  input  wire logic [9:0]            trp_ab,  // all-bank tRP count
  input  wire logic [7:0]            ras,     // tRAS count
  input  wire logic [9:0]            rd_dly,  // read ap delay
  input  wire logic [9:0]            wr_dly,  // write ap delay
  output pap_pkg::pap_bank_st_t      st,      // bank state
  output logic                       ras_ok,  // tRAS met
  output logic                       start    // auto-precharge began
);
  pap_pkg::pap_bank_st_t st_q, st_d;
  logic [9:0]            cnt_q, cnt_d;
  logic [7:0]            ras_q, ras_d;
  logic                  start_q, start_d;

  // cycles since activate, saturating
  assign ras_ok = (ras_q >= ras);

  // state, wait and countdown; explicit precharge beats a pending one
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    start_d = 1'b0;
    ras_d   = (ras_q == 8'hFF) ? ras_q : ras_q + 8'h01;
    case (st_q)
      pap_pkg::bk_closed: begin
        if (act) begin
          st_d  = pap_pkg::bk_open;
          ras_d = 8'h01;
        end
      end
      pap_pkg::bk_open: begin
        if (pre) begin
          st_d  = pap_pkg::bk_prech;
          cnt_d = pre_ab ? trp_ab : trp_pb;
        end else if (ap_rd || ap_wr) begin
          st_d  = pap_pkg::bk_apwait;
          // a zero delay would wrap the countdown, so it starts at once instead
          cnt_d = ((ap_rd ? rd_dly : wr_dly) == 10'h000) ? 10'h000 : (ap_rd ? rd_dly : wr_dly) - 10'h001;
        end
      end
      pap_pkg::bk_apwait: begin
        if (pre) begin
          st_d  = pap_pkg::bk_prech;
          cnt_d = pre_ab ? trp_ab : trp_pb;
        end else if (cnt_q > 10'h001) begin
          cnt_d = cnt_q - 10'h001;
        end else if (ras_ok) begin
          st_d    = pap_pkg::bk_prech;
          cnt_d   = trp_pb;
          start_d = 1'b1;
        end
      end
      pap_pkg::bk_prech: begin
        if (cnt_q <= 10'h001) st_d = pap_pkg::bk_closed;
        else cnt_d = cnt_q - 10'h001;
      end
      default: st_d = pap_pkg::bk_closed;
    endcase
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q    <= pap_pkg::bk_closed;
      cnt_q   <= 10'h000;
      ras_q   <= 8'h00;
      start_q <= 1'b0;
    end else if (ce) begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ras_q   <= ras_d;
      start_q <= start_d;
    end
  end

  assign st    = st_q;
  assign start = start_q;
endmodule : pap_bank

// *** verif/pap_host_model.sv ***
// host model: drives two-cycle commands on the device pins
// assumes the bench spaces commands as the host timing asks
`timescale 1ns/1ps
module pap_host_model (
  input  wire logic       sys_clk, // clock
  input  wire logic       go,      // start a command
  input  wire logic [4:0] op,      // command code
  input  wire logic       flag,    // all-bank or ap bit
  input  wire logic [2:0] bank,    // bank number
  output logic            cs_pin,  // chip select
  output logic      [5:0] ca_pin   // command/address
);
  logic       ph_q = 1'b0;  // second command cycle pending
  logic       cs_q = 1'b0;  // chip select image, idle low
  logic [5:0] ca_q = 6'h00; // command/address image
  // idle ca toggles so a stale value never helps the decoder
  always @(posedge sys_clk) begin
    if (ph_q) begin
      cs_q <= 1'b0;
      ca_q <= {3'h0, bank};
      ph_q <= 1'b0;
    end else if (go) begin
      cs_q <= 1'b1;
      ca_q <= {flag, op};
      ph_q <= 1'b1;
    end else begin
      ca_q <= ~ca_q;
    end
  end
  assign cs_pin = cs_q;
  assign ca_pin = ca_q;
endmodule : pap_host_model

// *** verif/tb_top.sv ***
// bench: registers, pin commands and timing of bank closes
// assumes the host model and the design are compiled first
`timescale 1ns/1ps
`include "pap_consts.svh"
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk, reset, ce, go, flag, wr_stb, rd_stb, rd_seen, cs_pin;
  logic [4:0]  op;
  logic [2:0]  bank, rb;
  logic [5:0]  ca_pin;
  logic [7:0]  addr, bank_open, bank_prech;
  logic [31:0] wdata, rd_data;
  logic [31:0] exp_q[$];
  int          failures, total_checks, seed, base, ref_n, n, i, d;
  localparam logic [4:0] ACT = {3'h0, `PAP_OP_ACT_LO};
  localparam int RTP_N = 8, WR_N = 3, WL_N = 2;
  logic [4:0]  ap_op[4] = '{`PAP_OP_RD, `PAP_OP_RD, `PAP_OP_WR, `PAP_OP_MWR};
  int          bl[4] = '{0, 1, 0, 1};
  pap_precharge dut_u (.sys_clk(sys_clk), .reset(reset), .ce(ce), .cs_pin(cs_pin), .ca_pin(ca_pin),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .bank_open(bank_open), .bank_prech(bank_prech));
  pap_host_model host_u (.sys_clk(sys_clk), .go(go), .op(op), .flag(flag), .bank(bank),
    .cs_pin(cs_pin), .ca_pin(ca_pin));
  always #5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic bad(input string m);
    failures++;
    $display("BAD t=%0t %s", $time, m);
  endtask : bad
  task automatic chk_r(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) bad("count out of range");
  endtask : chk_r
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) bad("bank bits");
  endtask : chk_b
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= v;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr
  // expected read value is queued, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr   <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd_stb <= 1'b0;
  endtask : rd
  task automatic cmd(input logic [4:0] o, input logic f, input logic [2:0] b);
    @(posedge sys_clk);
    go   <= 1'b1;
    op   <= o;
    flag <= f;
    bank <= b;
    @(posedge sys_clk);
    go   <= 0;
    idle(2);
  endtask : cmd
  // cycles from command to precharge start; a hang ends the run
  task automatic lat(input logic [4:0] o, input logic f, input logic [2:0] b);
    cmd(o, f, b);
    for (n = 0; bank_prech[b] !== 1'b1 && n < 500; n++) @(posedge sys_clk);
    if (n >= 500) begin
      bad("no precharge");
      print_verdict();
    end
  endtask : lat
  task automatic dur(input logic [2:0] b);
    for (n = 0; bank_prech[b] === 1'b1 && n < 500; n++) @(posedge sys_clk);
  endtask : dur
  // read data stands one cycle after the strobe only
  always @(posedge sys_clk) begin
    if (rd_seen === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0 || rd_data !== exp_q[0]) bad("register read");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    rd_seen <= rd_stb;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sys_clk, ce, go, flag, wr_stb, rd_stb, op, bank, addr, wdata} = '0;
    reset = 1'b1;
    ce    = 1'b1;
    seed  = 32'hc775_f76e;
    idle(5);
    reset <= 1'b0;
    rd(`PAP_ADDR_CTRL, `PAP_CTRL_RST);
    rd(`PAP_ADDR_TIM0, `PAP_TIM0_RST);
    rd(`PAP_ADDR_TIM1, `PAP_TIM1_RST);
    wr(`PAP_ADDR_STAT, 32'hFFFF_FFFF);
    rd(`PAP_ADDR_STAT, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    wr(`PAP_ADDR_TIM0, 32'h0006_0904);
    wr(`PAP_ADDR_TIM1, 32'h0002_0308);
    $display("test regs done");
    for (i = 0; i < 8; i++) cmd(ACT, 1'b0, 3'(i));
    idle(20);
    chk_b(bank_open, 8'hFF);
    rb = 3'($random(seed));
    lat(`PAP_OP_PRE, 1'b0, rb);
    base = n;
    dur(rb);
    chk_r(n, 4, 4);
    chk_b(bank_open, ~(8'h01 << rb));
    cmd(ACT, 1'b0, rb);
    idle(20);
    lat(`PAP_OP_PRE, 1'b1, 3'($random(seed)));
    dur(3'h0);
    chk_r(n, 9, 9);
    chk_b(bank_open, 8'h00);
    $display("test precharge done");
    for (i = 0; i < 4; i++) begin
      wr(`PAP_ADDR_CTRL, 32'(bl[i]));
      cmd(ACT, 1'b0, 3'(i));
      idle(20);
      lat(ap_op[i], 1'b1, 3'(i));
      if (i == 0) ref_n = n;
      if (i == 0) chk_r(n - base, RTP_N - 1, RTP_N + 1);
      d = (i < 2) ? RTP_N + 8 * bl[i] : WL_N + 8 * (1 + bl[i]) + 1 + WR_N;
      chk_r(n - ref_n, d - RTP_N, d - RTP_N);
      dur(3'(i));
      chk_r(n, 4, 4);
      idle(5);
    end
    wr(`PAP_ADDR_CTRL, 32'h0000_0000);
    $display("test auto done");
    cmd(ACT, 1'b0, 3'h6);
    cmd(`PAP_OP_RD, 1'b0, 3'h6);
    cmd(`PAP_OP_WR, 1'b0, 3'h6);
    cmd(`PAP_OP_MWR, 1'b0, 3'h6);
    idle(40);
    chk_b(bank_open, 8'h40);
    chk_b(bank_prech, 8'h00);
    rd(`PAP_ADDR_STAT, 32'h0000_0040);
    // read and write spacing long met; then three frozen edges stretch the close
    lat(`PAP_OP_PRE, 1'b0, 3'h6);
    ce <= 1'b0;
    idle(3);
    ce <= 1'b1;
    dur(3'h6);
    chk_r(n, 4, 4);
    chk_b(bank_open, 8'h00);
    // long row time pushes the close out past the read delay
    wr(`PAP_ADDR_TIM0, 32'h0028_0904);
    cmd(ACT, 1'b0, 3'h7);
    lat(`PAP_OP_RD, 1'b1, 3'h7);
    chk_r(n - ref_n, 29, 29);
    idle(10);
    $display("test lockout done");
    print_verdict();
  end
endmodule : tb_top
